// [bench/sdram_refresh_scheduler_bench.sv]
// Self-checking bench of the SDRAM refresh scheduler
`timescale 1ns/100ps
module sdram_refresh_scheduler_bench;
  logic                 clock_i = 1'b0;
  logic                 rst_n_i = 1'b0;
  logic [12:0]          period = 13'h0010;
  logic                 period_wr = 1'b0;
  logic                 cfg_wr = 1'b0;
  logic [3:0]           cfg_be = 4'h0;
  logic                 sr_req = 1'b0;
  srs_pkg::srs_timing_t tim = '0;
  srs_pkg::srs_access_t acc = '0;
  srs_pkg::srs_pin_t    pin;
  logic                 hold;
  logic                 busy;
  logic                 slf;
  logic [3:0]           bl;
  int                   refs;
  int                   faults;
  int                   miscompares = 0;
  int                   comparisons = 0;
  int                   n;
  int                   r0;
  int                   seed;
  logic                 done;
  int                   dones = 0;

  always #20 clock_i = ~clock_i;

  srs_refresh_scheduler uut (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .refresh_period_field_i(period),
    .refresh_period_wr_i(period_wr),
    .sdram_config_wr_i(cfg_wr),
    .sdram_config_be_i(cfg_be),
    .self_refresh_request_bit_i(sr_req),
    .timing_i(tim),
    .access_i(acc),
    .pin_o(pin),
    .hold_requests_o(hold),
    .init_busy_o(busy),
    .self_refresh_active_o(slf),
    .backlog_o(bl),
    .refresh_done_o(done)
  );

  // Count refresh-cycle completion pulses
  always @(posedge clock_i)
    if (done === 1'b1)
      dones++;

  srs_sdram_model sdram (
    .clock_i(clock_i),
    .pin_i(pin),
    .refreshes_o(refs),
    .faults_o(faults)
  );

  // Compare and count
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got)
    begin
      miscompares++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock_i);
  endtask

  function automatic logic flag(input int w);
    return w == 0 ? busy : w == 1 ? slf : hold;
  endfunction

  // Bounded wait on a status flag
  task automatic wait_flag(input int w, input logic v);
    n = 0;
    while (flag(w) !== v && n < 3000)
    begin
      cyc(1);
      n++;
    end
  endtask

  task automatic wait_bl(input logic [3:0] v);
    n = 0;
    while (bl !== v && n < 2000)
    begin
      cyc(1);
      n++;
    end
    check("backlog", {28'h0, v}, {28'h0, bl});
  endtask

  // Count precharge commands over a span
  task automatic count_pre(input int k);
    n = 0;
    repeat (k)
    begin
      cyc(1);
      if (pin.cmd === srs_pkg::CMD_PRE_ALL)
        n++;
    end
  endtask

  // One initialisation: wait span and refresh count
  task automatic init_check(input int p);
    r0 = refs;
    n = 0;
    while (pin.cmd !== srs_pkg::CMD_PRE_ALL && n < 3000)
    begin
      cyc(1);
      n++;
    end
    check("init wait", 32'h1, n >= 8 * (p + 1) - 2 && n <= 8 * (p + 1) + 8);
    wait_flag(0, 1'b0);
    cyc(1);
    check("init refreshes", 32'h9, refs - r0);
  endtask

  task automatic pulse_cfg(input logic [3:0] be);
    cfg_be = be;
    cfg_wr = 1'b1;
    cyc(1);
    cfg_wr = 1'b0;
  endtask

  task automatic new_period();
    period = 13'($urandom_range(47, 16));
    period_wr = 1'b1;
    cyc(1);
    period_wr = 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #(40 * 40000);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    seed = $urandom(63);
    period = 13'($urandom_range(47, 16));
    tim.t_rp = 4'($urandom_range(3, 1));
    tim.t_rfc = 4'($urandom_range(3, 1));
    tim.t_xs = 4'($urandom_range(3, 1));
    cyc(10);
    rst_n_i = 1'b1;
    init_check(period);
    wait_bl(4'h0);
    acc = 4'h2;
    wait_bl(4'h1);
    count_pre(period - 2);
    check("may, bank open", 32'h0, n);
    acc = 4'h0;
    count_pre(10);
    check("may, banks shut", 32'h1, n > 0);
    acc = 4'h2;
    wait_bl(4'h4);
    count_pre(10);
    check("release, bank open", 32'h1, n > 0);
    acc = 4'h5;
    new_period();
    wait_bl(bl + 4'h1);
    r0 = bl;
    n = 0;
    while (bl === 4'(r0) && n < 200)
    begin
      cyc(1);
      n++;
    end
    check("interval", period + 1, n);
    wait_bl(4'hf);
    cyc(2 * period + 2);
    check("saturate", 32'hf, bl);
    check("hold at must", 32'h1, hold);
    acc = 4'ha;
    wait_flag(2, 1'b0);
    check("must drain", 32'h1, bl <= 4'h8 && bl >= 4'h6);
    wait_bl(4'h8);
    count_pre(period - 2);
    check("need, reads", 32'h0, n);
    acc = 4'h4;
    count_pre(10);
    check("need, writes", 32'h1, n > 0);
    acc = 4'h1;
    wait_bl(4'h9);
    r0 = refs;
    acc = 4'h0;
    sr_req = 1'b1;
    pulse_cfg(4'h8);
    check("upper byte", 32'h0, busy);
    wait_flag(1, 1'b1);
    check("backlog first", 32'h1, refs - r0 >= 9);
    check("cke low", 32'h0, pin.cke);
    cyc(3 * period);
    sr_req = 1'b0;
    r0 = refs;
    pulse_cfg(4'h8);
    wait_flag(1, 1'b0);
    cyc(40);
    check("exit refresh", 32'h1, refs - r0 >= 1);
    check("self faults", 32'h0, faults);
    new_period();
    pulse_cfg(4'h1);
    init_check(period);
    new_period();
    repeat (300)
    begin
      acc = 4'($urandom);
      cyc(1 + $urandom_range(7, 0));
    end
    acc = 4'h0;
    wait_bl(4'h0);
    cyc(2);
    check("done pulses", refs - 16, dones);
    complete_run();
  end
endmodule // sdram_refresh_scheduler_bench

// [bench/srs_refresh_scheduler_properties.sv]
// Concurrent checks on the refresh scheduler ports
`timescale 1ns/100ps
module srs_props #(
  parameter int unsigned PERIOD_W = 13
) (
  // Clock and reset
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  // Configuration writes
  input wire logic              sdram_config_wr_i,
  input wire logic [3:0]        sdram_config_be_i,
  // Results
  input wire srs_pkg::srs_pin_t pin_o,
  input wire logic              hold_requests_o,
  input wire logic              init_busy_o,
  input wire logic [3:0]        backlog_o,
  input wire logic              refresh_done_o
);
  logic [4:0] since_pre_r;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  // Cycles since the last precharge-all, saturating
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i)
      since_pre_r <= 5'h1f;
    else if (pin_o.cmd == srs_pkg::CMD_PRE_ALL)
      since_pre_r <= 5'h00;
    else if (since_pre_r != 5'h1f)
      since_pre_r <= since_pre_r + 5'h01;

  a_backlog_step: assert property (
    1'b1 |=> backlog_o == $past(backlog_o)
      || (backlog_o == $past(backlog_o) + 4'h1 && $past(backlog_o) != 4'hf)
      || (backlog_o == $past(backlog_o) - 4'h1 && $past(backlog_o) != 4'h0))
    else $error("backlog jumped or wrapped");
  a_refresh_after_pre: assert property (
    pin_o.cmd == srs_pkg::CMD_REFRESH && !init_busy_o |-> since_pre_r <= 5'h11)
    else $error("refresh without precharge");
  a_done_after_ref: assert property (
    refresh_done_o |-> pin_o.cmd == srs_pkg::CMD_REFRESH)
    else $error("done pulse without refresh");
  a_hold_in_must: assert property (
    backlog_o >= 4'hc |=> hold_requests_o)
    else $error("requests open at must level");
  a_cfg_restart: assert property (
    sdram_config_wr_i && (|sdram_config_be_i[2:0]) |=> init_busy_o)
    else $error("config write did not restart init");
  a_upper_byte_keep: assert property (
    sdram_config_wr_i && sdram_config_be_i == 4'h8 && !init_busy_o |=> !init_busy_o)
    else $error("upper byte write restarted init");
  a_init_holds: assert property (
    init_busy_o |-> hold_requests_o)
    else $error("requests open during init");
  a_self_clean: assert property (
    pin_o.cmd == srs_pkg::CMD_SELF_REF |-> !pin_o.cke && since_pre_r <= 5'h11)
    else $error("self refresh entered badly");
  a_cmd_with_cke: assert property (
    pin_o.cmd != srs_pkg::CMD_NOP && pin_o.cmd != srs_pkg::CMD_SELF_REF |-> pin_o.cke)
    else $error("command with clock enable low");
endmodule // srs_props

bind srs_refresh_scheduler srs_props #(.PERIOD_W(PERIOD_W)) props_i (
  .clock_i(clock_i),
  .rst_n_i(rst_n_i),
  .sdram_config_wr_i(sdram_config_wr_i),
  .sdram_config_be_i(sdram_config_be_i),
  .pin_o(pin_o),
  .hold_requests_o(hold_requests_o),
  .init_busy_o(init_busy_o),
  .backlog_o(backlog_o),
  .refresh_done_o(refresh_done_o)
);

// [bench/srs_sdram_model.sv]
// SDRAM model: counts refreshes and flags commands while asleep
`timescale 1ns/100ps
module srs_sdram_model (
  // Clock
  input  wire logic              clock_i,
  // Command pins from the scheduler
  input  wire srs_pkg::srs_pin_t pin_i,
  // Counts for the bench
  output int                     refreshes_o,
  output int                     faults_o
);
  logic asleep_r = 1'b0;

  initial
  begin
    refreshes_o = 0;
    faults_o = 0;
  end

  // Self refresh lasts until the clock enable returns
  always @(posedge clock_i)
  begin
    if (asleep_r && pin_i.cmd != srs_pkg::CMD_NOP)
      faults_o <= faults_o + 1;
    if (pin_i.cmd == srs_pkg::CMD_REFRESH)
      refreshes_o <= refreshes_o + 1;
    asleep_r <= pin_i.cmd == srs_pkg::CMD_SELF_REF || (asleep_r && !pin_i.cke);
  end
endmodule // srs_sdram_model

// [shared/srs_pkg.sv]
// Shared constants and types of the SDRAM refresh scheduler
package srs_pkg;

  // Counter widths
  localparam int unsigned INTERVAL_W = 13;
  localparam int unsigned BACKLOG_W  = 4;
  localparam int unsigned GAP_W      = 4;

  // Backlog limits and urgency thresholds
  localparam logic [3:0] BACKLOG_MIN   = 4'h0;
  localparam logic [3:0] BACKLOG_MAX   = 4'hf;
  localparam logic [3:0] LVL_MAY       = 4'h1;
  localparam logic [3:0] LVL_RELEASE   = 4'h4;
  localparam logic [3:0] LVL_NEED      = 4'h8;
  localparam logic [3:0] LVL_MUST      = 4'hc;
  localparam logic [3:0] RELEASE_TOP   = 4'h7;

  // Initialisation counts
  localparam logic [3:0] INIT_INTERVALS = 4'h8;
  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  localparam logic [3:0] LMR_GAP        = 4'h2;

  // Values after reset
  localparam logic [12:0] INTERVAL_RST = 13'h0000;
  localparam logic [3:0]  BACKLOG_RST  = 4'h0;
  localparam logic [3:0]  CNT_RST      = 4'h0;
  localparam logic [3:0]  GAP_RST      = 4'h0;

  // Commands driven to the SDRAM
  typedef enum logic [2:0] {
    CMD_NOP      = 3'h0,
    CMD_PRE_ALL  = 3'h1,
    CMD_REFRESH  = 3'h2,
    CMD_LOAD_MR  = 3'h3,
    CMD_SELF_REF = 3'h4
  } srs_cmd_e_t;

  // Scheduler states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_INIT_OPEN = 4'h1,
    ST_INIT_WAIT = 4'h2,
    ST_INIT_PRE  = 4'h3,
    ST_INIT_REF  = 4'h4,
    ST_INIT_LMR  = 4'h5,
    ST_REF_PRE   = 4'h6,
    ST_REF_CMD   = 4'h7,
    ST_SLF_PRE   = 4'h8,
    ST_SLF_ENTER = 4'h9,
    ST_SELF      = 4'ha,
    ST_SLF_EXIT  = 4'hb
  } srs_state_t;

  // Command bundle to the pins
  typedef struct packed {
    srs_cmd_e_t cmd;
    logic       cke;
  } srs_pin_t;

  // Pending work seen from the access sequencer
  typedef struct packed {
    logic read_pending;
    logic write_pending;
    logic bank_open;
    logic access_busy;
  } srs_access_t;

  // Timing fields taken from the timing registers
  typedef struct packed {
    logic [3:0] t_rp;
    logic [3:0] t_rfc;
    logic [3:0] t_xs;
  } srs_timing_t;

endpackage

// [src/srs_refresh_scheduler.sv]
// SDRAM refresh scheduler: interval and backlog counters, urgency, init and self-refresh
`timescale 1ns/100ps

// Behaviour
// - 13-bit interval counter loads, then decrements
// - Zero reloads counter and adds one backlog
// - 4-bit backlog increments, never above maximum
// - Refresh decrements backlog, saturating both ends
// - Refresh cycle: precharge all, then refresh
// - Refresh always runs, no disable
// - Backlog 1-3: idle and banks closed
// - Backlog 4-7: refresh when no requests
// - Backlog 8-11: after access unless reads
// - Backlog 12-15: drain to seven, hold requests
// - Full config write reruns initialisation
// - Init: NOPs, precharge, eight refreshes, LMR, refresh
// - Init on reset or config write to any of bytes 0-2
// - Self-refresh after access and backlog cleared
module srs_refresh_scheduler #(
  parameter int unsigned PERIOD_W = 13
) (
  // Clock and reset
  input  wire logic                        clock_i,
  input  wire logic                        rst_n_i,
  // Refresh period field and its write strobe
  input  wire logic [PERIOD_W-1:0]         refresh_period_field_i,
  input  wire logic                        refresh_period_wr_i,
  // Configuration register write with byte enables
  input  wire logic                        sdram_config_wr_i,
  input  wire logic [3:0]                  sdram_config_be_i,
  input  wire logic                        self_refresh_request_bit_i,
  // Timing fields
  input  wire srs_pkg::srs_timing_t        timing_i,
  // Access sequencer status
  input  wire srs_pkg::srs_access_t        access_i,
  // SDRAM command and clock enable pin
  output srs_pkg::srs_pin_t                pin_o,
  // Status
  output logic                             hold_requests_o,
  output logic                             init_busy_o,
  output logic                             self_refresh_active_o,
  output logic [srs_pkg::BACKLOG_W-1:0]    backlog_o,
  output logic                             refresh_done_o
);

  // Reset release synchroniser
  logic rst_meta_r;
  logic rst_sync_n_r;

  // Interval and backlog state
  logic [PERIOD_W-1:0]            interval_r;
  logic [PERIOD_W-1:0]            interval_nxt;
  logic [srs_pkg::BACKLOG_W-1:0]  backlog_r;
  logic [srs_pkg::BACKLOG_W-1:0]  backlog_nxt;
  logic                           load_pend_r;
  logic                           must_r;
  logic                           must_nxt;
  logic                           expiry;
  logic                           ref_issue;

  // Sequencer state
  srs_pkg::srs_state_t            state_r;
  srs_pkg::srs_state_t            state_nxt;
  logic [3:0]                     cnt_r;
  logic [3:0]                     cnt_nxt;
  logic [srs_pkg::GAP_W-1:0]      gap_r;
  logic [srs_pkg::GAP_W-1:0]      gap_nxt;
  logic                           init_pend_r;
  logic                           init_pend_nxt;
  srs_pkg::srs_pin_t              pin_r;
  srs_pkg::srs_pin_t              pin_nxt;
  logic                           done_r;
  logic                           init_go;
  logic                           req_pending;
  logic                           gap_zero;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_r   <= 1'b0;
      rst_sync_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r   <= 1'b1;
      rst_sync_n_r <= rst_meta_r;
    end
  end

  // Request and start conditions
  assign req_pending = access_i.read_pending | access_i.write_pending;
  assign init_go     = load_pend_r | (sdram_config_wr_i & (|sdram_config_be_i[2:0]));
  assign gap_zero    = (gap_r == srs_pkg::GAP_RST);
  assign expiry      = ~load_pend_r & ~refresh_period_wr_i & (interval_r == '0);

  // Interval counter, backlog and the Refresh Must latch
  always_comb
  begin
    interval_nxt = interval_r - PERIOD_W'(1);
    if (load_pend_r || refresh_period_wr_i || expiry)
      interval_nxt = refresh_period_field_i;
    backlog_nxt = backlog_r;
    if (expiry && !ref_issue && backlog_r != srs_pkg::BACKLOG_MAX)
      backlog_nxt = backlog_r + 4'h1;
    else if (ref_issue && !expiry && backlog_r != srs_pkg::BACKLOG_MIN)
      backlog_nxt = backlog_r - 4'h1;
    must_nxt = must_r;                                           // neither leaves as is
    if (backlog_r >= srs_pkg::LVL_MUST)
      must_nxt = 1'b1;
    else if (backlog_r <= srs_pkg::RELEASE_TOP)
      must_nxt = 1'b0;
  end

  // Counter registers
  always_ff @(posedge clock_i or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      interval_r  <= PERIOD_W'(srs_pkg::INTERVAL_RST);
      backlog_r   <= srs_pkg::BACKLOG_RST;
      load_pend_r <= 1'b1;                                       // Load period after release
      must_r      <= 1'b0;
    end
    else
    begin
      interval_r  <= interval_nxt;
      backlog_r   <= backlog_nxt;
      load_pend_r <= 1'b0;
      must_r      <= must_nxt;
    end
  end

  // Command sequencer
  always_comb
  begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    gap_nxt       = gap_zero ? gap_r : gap_r - 4'h1;
    init_pend_nxt = init_pend_r;
    pin_nxt.cmd   = srs_pkg::CMD_NOP;
    pin_nxt.cke   = 1'b1;                                        // CKE high
    ref_issue     = 1'b0;
    unique case (state_r)
      srs_pkg::ST_IDLE:
      begin
        if (gap_zero && !access_i.access_busy)
        begin
          if (must_r || backlog_r >= srs_pkg::LVL_MUST)
            state_nxt = srs_pkg::ST_REF_PRE;
          else if (self_refresh_request_bit_i && !req_pending)
            state_nxt = (backlog_r != srs_pkg::BACKLOG_MIN) ?
                        srs_pkg::ST_REF_PRE : srs_pkg::ST_SLF_PRE;
          else if (backlog_r >= srs_pkg::LVL_NEED && !access_i.read_pending)
            state_nxt = srs_pkg::ST_REF_PRE;
          else if (backlog_r >= srs_pkg::LVL_RELEASE && !req_pending)
            state_nxt = srs_pkg::ST_REF_PRE;
          else if (backlog_r >= srs_pkg::LVL_MAY && !req_pending && !access_i.bank_open)
            state_nxt = srs_pkg::ST_REF_PRE;
        end
      end
      srs_pkg::ST_INIT_OPEN:
      begin
        if (access_i.bank_open)
        begin
          pin_nxt.cmd = srs_pkg::CMD_PRE_ALL;                    // Close rows before waiting
          gap_nxt     = timing_i.t_rp;
        end
        state_nxt = srs_pkg::ST_INIT_WAIT;
      end
      srs_pkg::ST_INIT_WAIT:
      begin
        if (expiry)
          cnt_nxt = cnt_r + 4'h1;                                // count intervals
        if (cnt_r == srs_pkg::INIT_INTERVALS)
        begin
          cnt_nxt   = srs_pkg::CNT_RST;
          state_nxt = srs_pkg::ST_INIT_PRE;
        end
      end
      srs_pkg::ST_INIT_PRE:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_PRE_ALL;
          gap_nxt     = timing_i.t_rp;
          state_nxt   = srs_pkg::ST_INIT_REF;
        end
      end
      srs_pkg::ST_INIT_REF:
      begin
        if (cnt_r == srs_pkg::INIT_REFRESHES)
        begin
          cnt_nxt   = srs_pkg::CNT_RST;
          state_nxt = srs_pkg::ST_INIT_LMR;
        end
        else if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_REFRESH;                    // eight refreshes
          gap_nxt     = timing_i.t_rfc;
          cnt_nxt     = cnt_r + 4'h1;
        end
      end
      srs_pkg::ST_INIT_LMR:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_LOAD_MR;
          gap_nxt     = srs_pkg::LMR_GAP;
          state_nxt   = srs_pkg::ST_REF_PRE;
        end
      end
      srs_pkg::ST_REF_PRE:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_PRE_ALL;
          gap_nxt     = timing_i.t_rp;
          state_nxt   = srs_pkg::ST_REF_CMD;
        end
      end
      srs_pkg::ST_REF_CMD:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd   = srs_pkg::CMD_REFRESH;
          gap_nxt       = timing_i.t_rfc;
          ref_issue     = 1'b1;
          init_pend_nxt = 1'b0;
          state_nxt     = srs_pkg::ST_IDLE;
        end
      end
      srs_pkg::ST_SLF_PRE:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_PRE_ALL;
          gap_nxt     = timing_i.t_rp;
          state_nxt   = srs_pkg::ST_SLF_ENTER;
        end
      end
      srs_pkg::ST_SLF_ENTER:
      begin
        if (gap_zero)
        begin
          pin_nxt.cmd = srs_pkg::CMD_SELF_REF;
          pin_nxt.cke = 1'b0;
          state_nxt   = srs_pkg::ST_SELF;
        end
      end
      srs_pkg::ST_SELF:
      begin
        pin_nxt.cke = 1'b0;
        if (!self_refresh_request_bit_i || req_pending)
        begin
          pin_nxt.cke = 1'b1;                                    // Exit with CKE high
          gap_nxt     = timing_i.t_xs;
          state_nxt   = srs_pkg::ST_SLF_EXIT;
        end
      end
      srs_pkg::ST_SLF_EXIT:
      begin
        if (gap_zero)
          state_nxt = srs_pkg::ST_REF_PRE;                       // Exit refresh cycle
      end
      default:
      begin
        state_nxt = srs_pkg::ST_IDLE;
      end
    endcase
    // A qualifying config write restarts the whole sequence
    if (init_go)
    begin
      state_nxt     = srs_pkg::ST_INIT_OPEN;
      cnt_nxt       = srs_pkg::CNT_RST;
      gap_nxt       = srs_pkg::GAP_RST;
      init_pend_nxt = 1'b1;
      pin_nxt.cmd   = srs_pkg::CMD_NOP;
      pin_nxt.cke   = 1'b1;
      ref_issue     = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock_i or negedge rst_sync_n_r)
  begin
    if (!rst_sync_n_r)
    begin
      state_r     <= srs_pkg::ST_IDLE;
      cnt_r       <= srs_pkg::CNT_RST;
      gap_r       <= srs_pkg::GAP_RST;
      init_pend_r <= 1'b1;
      pin_r.cmd   <= srs_pkg::CMD_NOP;
      pin_r.cke   <= 1'b0;
      done_r      <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      gap_r       <= gap_nxt;
      init_pend_r <= init_pend_nxt;
      pin_r       <= pin_nxt;
      done_r      <= ref_issue;
    end
  end

  // Outputs
  assign pin_o                 = pin_r;
  assign backlog_o             = backlog_r;
  assign refresh_done_o        = done_r;
  assign init_busy_o           = init_pend_r;
  assign self_refresh_active_o = (state_r == srs_pkg::ST_SELF);
  assign hold_requests_o       = init_pend_r | must_r | (state_r != srs_pkg::ST_IDLE);

endmodule // srs_refresh_scheduler
